// File: serial_bus_unit_pkg.sv
/*
 * Constants for the serial bus unit control front end: register offsets,
 * field positions, reset values, mode codes and timing counts.
 * Assumes a 40 MHz pclk and a 32-bit APB register bus.
 */
`default_nettype none

package serial_bus_unit_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_IFACE_ENABLE_CTRL    = 8'h00;
    localparam logic [7:0] OFS_TRANSFER_FORMAT_CTRL = 8'h04;
    localparam logic [7:0] OFS_DATA_BUFFER          = 8'h08;
    localparam logic [7:0] OFS_OWN_BUS_ADDRESS      = 8'h0c;
    localparam logic [7:0] OFS_BUS_COMMAND_CTRL     = 8'h10;
    localparam logic [7:0] OFS_BAUD_CTRL_ZERO       = 8'h14;

    // Enable register
    localparam int BIT_BUS_IFACE_ENABLE = 7;

    // Transfer format register
    localparam int BIT_BC_LO            = 5;
    localparam int BIT_ACK              = 4;
    localparam int BIT_FMT_ONE          = 3;
    localparam int BIT_SCK_LO           = 0;
    localparam logic [2:0] RST_BIT_COUNT = 3'h0;
    localparam logic [2:0] RST_SCL_RATE  = 3'h0;
    localparam logic [2:0] SCL_RATE_RESERVED = 3'h7;
    localparam logic [3:0] FULL_BYTE_BITS    = 4'h8;

    // Command register / status register
    localparam int BIT_MASTER   = 7;
    localparam int BIT_TRANSMIT = 6;
    localparam int BIT_START    = 5;
    localparam int BIT_IRQ      = 4;
    localparam int BIT_MODE_LO  = 2;
    localparam int BIT_SWR_LO   = 0;
    localparam logic [1:0] SWR_ARM  = 2'h2;
    localparam logic [1:0] SWR_FIRE = 2'h1;

    // Baud register 0
    localparam int BIT_IDLE_RUN = 6;
    localparam logic [7:0] BAUD_FIXED_ONES = 8'hbe;

    // Operating modes
    localparam logic [1:0] MODE_PORT = 2'h0;
    localparam logic [1:0] MODE_SIO  = 2'h1;
    localparam logic [1:0] MODE_I2C  = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;

    // SCL divider: period = 2^(code + base) + offset
    localparam int SCL_EXP_BASE = 5;
    localparam int SCL_OFFSET   = 72;

    // Timing
    localparam int CLK_PERIOD_PS   = 25000;
    localparam int SOFT_RST_NS     = 100;
    localparam int SOFT_RST_CYCLES = (SOFT_RST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage

`default_nettype wire

// File: serial_bus_unit_ctrl.sv
/*
 * Control and status front end of one serial bus unit channel: APB register
 * file, module enable with clock gate request, transfer format, SCL rate
 * divider, mode select, start/stop requests, soft reset and interrupt flag.
 * Assumes a transfer engine on the same pclk reporting bus events as
 * one-cycle pulses or levels; the engine gates its clock with clk_gate_en.
 */
`timescale 1ns/1ps
`default_nettype none

module serial_bus_unit_ctrl
    import serial_bus_unit_pkg::*;
#(
    parameter int SOFT_RST_LEN = SOFT_RST_CYCLES
) (
    input  wire logic        pclk,            // System clock, 40 MHz
    input  wire logic        presetn,         // Async reset, active low
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB access phase
    input  wire logic        pwrite,          // APB direction
    input  wire logic [7:0]  paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error, unmapped address
    input  wire logic        start_detected,  // Engine: start seen on bus
    input  wire logic        stop_detected,   // Engine: stop seen on bus
    input  wire logic        arb_lost,        // Engine: arbitration lost
    input  wire logic        xfer_done,       // Engine: transfer finished
    input  wire logic        bus_busy_in,     // Engine: bus busy level
    input  wire logic        addr_match_in,   // Engine: address matched
    input  wire logic        gen_call_in,     // Engine: general call seen
    input  wire logic        last_bit_in,     // Engine: last received bit
    input  wire logic [7:0]  rx_data_in,      // Engine: received byte
    input  wire logic        rx_load,         // Engine: received byte valid
    output logic             clk_gate_en,     // Clock gate enable for engine
    output logic             scl_tick,        // One pulse per SCL period
    output logic [3:0]       xfer_clocks,     // SCL clocks in next transfer
    output logic [3:0]       data_bits,       // Data bits in next transfer
    output logic             ack_mode,        // Acknowledge mode
    output logic             master_select,   // Master role
    output logic             transmit_select, // Transmit direction
    output logic [1:0]       iface_mode,      // Operating mode
    output logic             start_req,       // Pulse: generate start
    output logic             stop_req,        // Pulse: generate stop
    output logic             soft_reset_busy, // Engine soft reset level
    output logic [7:0]       tx_data,         // Transmit byte
    output logic             tx_load,         // Pulse: transmit byte written
    output logic [7:0]       own_addr,        // Own address and format bit
    output logic             idle_run,        // Run in idle mode
    output logic             serial_bus_irq   // Interrupt request
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [3:0] len_of(input logic [2:0] bc);
        len_of = (bc == 3'h0) ? FULL_BYTE_BITS : {1'b0, bc};
    endfunction

    function automatic logic [15:0] scl_period(input logic [2:0] code);
        logic [4:0] e;
        e = 5'(code) + 5'(SCL_EXP_BASE);
        scl_period = (16'h1 << e) + 16'(SCL_OFFSET);
    endfunction

    localparam int SRW = $clog2(SOFT_RST_LEN + 1);

    ////////////////////////////////////////////////////////////////////////
    // State

    logic        enable_ff;
    logic        ever_en_ff;
    logic [2:0]  bc_ff;
    logic        ack_ff;
    logic [2:0]  sck_ff;
    logic        mst_ff;
    logic        trx_ff;
    logic        pin_ff;
    logic [1:0]  mode_ff;
    logic        swr_armed_ff;
    logic [SRW-1:0] srst_cnt_ff;
    logic        al_ff;
    logic        aas_ff;
    logic        ado_ff;
    logic        lrb_ff;
    logic        bb_ff;
    logic [7:0]  rxbuf_ff;
    logic [7:0]  txbuf_ff;
    logic        tx_load_ff;
    logic [7:0]  addr_ff;
    logic        idle_ff;
    logic        start_ff;
    logic        stop_ff;
    logic [15:0] div_ff;
    logic        tick_ff;
    logic [31:0] prdata_ff;
    logic        pready_ff;
    logic        pslverr_ff;
    logic        irq_ff;

    logic        wr_done;
    logic        cfg_wr;
    logic        sr_active;
    logic        mapped;
    logic [31:0] nxt_prdata;

    assign wr_done   = psel && penable && pready_ff && pwrite;
    assign cfg_wr    = wr_done && enable_ff && !sr_active;
    assign sr_active = (srst_cnt_ff != '0);
    assign mapped    = (paddr == OFS_IFACE_ENABLE_CTRL) || (paddr == OFS_TRANSFER_FORMAT_CTRL)
                    || (paddr == OFS_DATA_BUFFER) || (paddr == OFS_OWN_BUS_ADDRESS)
                    || (paddr == OFS_BUS_COMMAND_CTRL) || (paddr == OFS_BAUD_CTRL_ZERO);

    ////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, registered answer

    always_comb begin
        nxt_prdata = 32'h0;
        if (ever_en_ff || paddr == OFS_IFACE_ENABLE_CTRL) begin
            unique case (paddr)
                OFS_IFACE_ENABLE_CTRL:    nxt_prdata[BIT_BUS_IFACE_ENABLE] = enable_ff;
                OFS_TRANSFER_FORMAT_CTRL: nxt_prdata[7:0] = {bc_ff, ack_ff, 1'b1, sck_ff[2:1],
                                                             !sr_active};
                OFS_DATA_BUFFER:          nxt_prdata[7:0] = rxbuf_ff;
                OFS_OWN_BUS_ADDRESS:      nxt_prdata[7:0] = addr_ff;
                OFS_BUS_COMMAND_CTRL:     nxt_prdata[7:0] = {mst_ff, trx_ff, bb_ff, pin_ff,
                                                             al_ff, aas_ff, ado_ff, lrb_ff};
                OFS_BAUD_CTRL_ZERO:       nxt_prdata[7:0] = BAUD_FIXED_ONES | {1'b0, idle_ff, 6'h0};
                default:                  nxt_prdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            prdata_ff  <= 32'h0;
            pslverr_ff <= 1'b0;
        end else if (psel && penable && !pready_ff) begin
            pready_ff  <= 1'b1;
            prdata_ff  <= pwrite ? 32'h0 : nxt_prdata;
            pslverr_ff <= !mapped;
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Enable register, always clocked

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_ff  <= 1'b0;
            ever_en_ff <= 1'b0;
        end else if (wr_done && paddr == OFS_IFACE_ENABLE_CTRL) begin
            enable_ff  <= pwdata[BIT_BUS_IFACE_ENABLE];
            if (pwdata[BIT_BUS_IFACE_ENABLE])
                ever_en_ff <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer format and rate; held while disabled

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bc_ff  <= RST_BIT_COUNT;
            ack_ff <= 1'b0;
            sck_ff <= RST_SCL_RATE;
        end else if (enable_ff) begin
            if (start_detected)
                bc_ff <= 3'h0;
            else if (cfg_wr && paddr == OFS_TRANSFER_FORMAT_CTRL)
                bc_ff <= pwdata[BIT_BC_LO +: 3];
            if (cfg_wr && paddr == OFS_TRANSFER_FORMAT_CTRL) begin
                ack_ff <= pwdata[BIT_ACK];
                sck_ff <= pwdata[BIT_SCK_LO +: 3];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Command register and soft reset

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mst_ff       <= 1'b0;
            trx_ff       <= 1'b0;
            mode_ff      <= MODE_PORT;
            swr_armed_ff <= 1'b0;
            srst_cnt_ff  <= '0;
            start_ff     <= 1'b0;
            stop_ff      <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            stop_ff  <= 1'b0;
            if (sr_active)
                srst_cnt_ff <= srst_cnt_ff - SRW'(1);
            if (enable_ff) begin
                if (cfg_wr && paddr == OFS_BUS_COMMAND_CTRL) begin
                    mst_ff  <= pwdata[BIT_MASTER];
                    trx_ff  <= pwdata[BIT_TRANSMIT];
                    mode_ff <= pwdata[BIT_MODE_LO +: 2];
                    if (mode_ff == MODE_I2C || pwdata[BIT_MODE_LO +: 2] == MODE_I2C) begin
                        start_ff <= pwdata[BIT_START];
                        stop_ff  <= !pwdata[BIT_START];
                    end
                    if (pwdata[BIT_SWR_LO +: 2] == SWR_ARM)
                        swr_armed_ff <= 1'b1;
                    else if (pwdata[BIT_SWR_LO +: 2] == SWR_FIRE && swr_armed_ff) begin
                        swr_armed_ff <= 1'b0;
                        srst_cnt_ff  <= SRW'(SOFT_RST_LEN);
                        mode_ff      <= MODE_I2C;
                        mst_ff       <= 1'b0;
                        trx_ff       <= 1'b0;
                        start_ff     <= 1'b0;
                        stop_ff      <= 1'b0;
                    end else if (pwdata[BIT_SWR_LO +: 2] != 2'h0)
                        swr_armed_ff <= 1'b0;
                end
                if (stop_detected || arb_lost) begin
                    mst_ff <= 1'b0;
                    trx_ff <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags; hardware set wins over software clear

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ff <= 1'b1;
            al_ff  <= 1'b0;
            aas_ff <= 1'b0;
            ado_ff <= 1'b0;
            lrb_ff <= 1'b0;
            bb_ff  <= 1'b0;
        end else if (sr_active) begin
            pin_ff <= 1'b1;
            al_ff  <= 1'b0;
            aas_ff <= 1'b0;
            ado_ff <= 1'b0;
        end else if (enable_ff) begin
            if (xfer_done || arb_lost)
                pin_ff <= 1'b0;
            else if (cfg_wr && paddr == OFS_BUS_COMMAND_CTRL && pwdata[BIT_IRQ])
                pin_ff <= 1'b1;
            if (arb_lost)
                al_ff <= 1'b1;
            else if (start_detected)
                al_ff <= 1'b0;
            aas_ff <= addr_match_in || gen_call_in;
            ado_ff <= gen_call_in;
            lrb_ff <= last_bit_in;
            bb_ff  <= bus_busy_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data, address and baud registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxbuf_ff   <= 8'h0;
            txbuf_ff   <= 8'h0;
            tx_load_ff <= 1'b0;
            addr_ff    <= 8'h0;
            idle_ff    <= 1'b0;
        end else begin
            tx_load_ff <= 1'b0;
            if (enable_ff) begin
                if (rx_load)
                    rxbuf_ff <= rx_data_in;
                if (cfg_wr && paddr == OFS_DATA_BUFFER) begin
                    txbuf_ff   <= pwdata[7:0];
                    tx_load_ff <= 1'b1;
                end
                if (cfg_wr && paddr == OFS_OWN_BUS_ADDRESS)
                    addr_ff <= pwdata[7:0];
                if (cfg_wr && paddr == OFS_BAUD_CTRL_ZERO)
                    idle_ff <= pwdata[BIT_IDLE_RUN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // SCL rate divider; stands still for the reserved code

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff  <= 16'h0;
            tick_ff <= 1'b0;
        end else if (!enable_ff || !mst_ff || mode_ff != MODE_I2C
                     || sck_ff == SCL_RATE_RESERVED || sr_active) begin
            div_ff  <= 16'h0;
            tick_ff <= 1'b0;
        end else if (div_ff >= scl_period(sck_ff) - 16'h1) begin
            div_ff  <= 16'h0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 16'h1;
            tick_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt output

    function automatic logic nxt_pin_clear_view();
        nxt_pin_clear_view = pin_ff || (cfg_wr && paddr == OFS_BUS_COMMAND_CTRL && pwdata[BIT_IRQ])
                             || sr_active;
    endfunction

    // Soft reset forces the flag to cleared, so the output follows it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_ff <= 1'b0;
        else if (sr_active)
            irq_ff <= 1'b0;
        else if (enable_ff)
            irq_ff <= (xfer_done || arb_lost) ? 1'b1 : !nxt_pin_clear_view();
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign clk_gate_en     = enable_ff;
    assign scl_tick        = tick_ff;
    assign data_bits       = len_of(bc_ff);
    assign xfer_clocks     = len_of(bc_ff) + {3'h0, ack_ff};
    assign ack_mode        = ack_ff;
    assign master_select   = mst_ff;
    assign transmit_select = trx_ff;
    assign iface_mode      = mode_ff;
    assign start_req       = start_ff;
    assign stop_req        = stop_ff;
    assign soft_reset_busy = sr_active;
    assign tx_data         = txbuf_ff;
    assign tx_load         = tx_load_ff;
    assign own_addr        = addr_ff;
    assign idle_run        = idle_ff;
    assign serial_bus_irq  = irq_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_irq_follows_flag: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (serial_bus_irq == !pin_ff)) else $error("irq does not mirror interrupt flag");

    a_pin_clear_write: assert property (@(posedge pclk) disable iff (!presetn)
        (cfg_wr && paddr == OFS_BUS_COMMAND_CTRL && pwdata[BIT_IRQ] && !xfer_done && !arb_lost)
        |=> pin_ff) else $error("interrupt flag not cleared by write");

    a_pin_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
        (enable_ff && !sr_active && xfer_done) |=> !pin_ff) else $error("done event lost");

    a_start_forces_bc: assert property (@(posedge pclk) disable iff (!presetn)
        (enable_ff && start_detected) |=> (bc_ff == 3'h0 && data_bits == 4'h8))
        else $error("bit count not forced on start");

    a_stop_clears_role: assert property (@(posedge pclk) disable iff (!presetn)
        (enable_ff && (stop_detected || arb_lost)) |=> (!mst_ff && !trx_ff))
        else $error("role not cleared after stop or arbitration loss");

    a_hold_disabled: assert property (@(posedge pclk) disable iff (!presetn)
        !enable_ff |=> ($stable(bc_ff) && $stable(sck_ff) && $stable(addr_ff) && $stable(ack_ff)))
        else $error("register changed while disabled");

    a_gate_off_tick: assert property (@(posedge pclk) disable iff (!presetn)
        !enable_ff |=> !scl_tick) else $error("scl tick while disabled");

    a_clock_count: assert property (@(posedge pclk) disable iff (!presetn)
        (xfer_clocks == data_bits + {3'h0, ack_mode})) else $error("clock count wrong");

    a_soft_reset_len: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(sr_active) |-> (sr_active [*4]) ##1 (!sr_active && mode_ff == MODE_I2C))
        else $error("soft reset length or mode wrong");

    // Cycles between SCL ticks while the divider runs on code 000
    localparam logic [15:0] SCL_GAP_000 = 16'((1 << SCL_EXP_BASE) + SCL_OFFSET - 1);
    logic [15:0] tick_gap_ff;
    logic        gap_valid_ff;
    logic        gap_run;

    assign gap_run = enable_ff && mst_ff && mode_ff == MODE_I2C && sck_ff == 3'h0 && !sr_active;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_gap_ff  <= 16'h0;
            gap_valid_ff <= 1'b0;
        end else if (!gap_run) begin
            tick_gap_ff  <= 16'h0;
            gap_valid_ff <= 1'b0;
        end else if (scl_tick) begin
            tick_gap_ff  <= 16'h0;
            gap_valid_ff <= 1'b1;
        end else begin
            tick_gap_ff  <= tick_gap_ff + 16'h1;
        end
    end

    a_scl_period: assert property (@(posedge pclk) disable iff (!presetn)
        (scl_tick && gap_valid_ff) |-> (tick_gap_ff == SCL_GAP_000))
        else $error("scl period wrong for code 000");

endmodule

`default_nettype wire

// File: engine_model.sv
/*
 * Transfer engine stand-in: bus events on bench command, busy level.
 * Assumes the bench drives ev for one cycle right after a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module engine_model (
    input  wire logic       pclk,      // Clock
    input  wire logic       presetn,   // Reset, active low
    input  wire logic [2:0] ev,        // Event: 1 done, 2 stop, 3 start, 4 lost
    input  wire logic       start_req, // Start request
    output logic            xfer_done, // Transfer finished
    output logic            stop_det,  // Stop seen
    output logic            start_det, // Start seen
    output logic            arb_lost,  // Arbitration lost to another master
    output logic            busy       // Bus busy level
);
    assign xfer_done = (ev == 3'h1);
    assign stop_det  = (ev == 3'h2);
    assign start_det = (ev == 3'h3);
    assign arb_lost  = (ev == 3'h4);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) busy <= 1'b0;
        else if (start_req) busy <= 1'b1;
        else if (stop_det) busy <= 1'b0;
    end
endmodule
`default_nettype wire

// File: tb_serial_bus_unit_ctrl.sv
/*
 * Testbench for the serial bus unit control front end over APB.
 * Assumes one wait state per access and the engine model beside it.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_bus_unit_ctrl;
    import serial_bus_unit_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, se, xd, sd, st, al, bz, ms, ts, sr, sp, tk, ge, irq;
    logic [2:0] ev = 3'h0;
    logic [1:0] md;
    logic [3:0] xc, db;
    int num_errors = 0, n_tests = 0, cyc = 0;
    int t0 = 0;
    serial_bus_unit_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .start_detected(st), .stop_detected(sd), .arb_lost(al),
        .xfer_done(xd), .bus_busy_in(bz), .addr_match_in(1'b0), .gen_call_in(1'b0),
        .last_bit_in(1'b0), .rx_data_in(pwdata[7:0]), .rx_load(1'b0), .clk_gate_en(ge),
        .scl_tick(tk), .xfer_clocks(xc), .data_bits(db), .ack_mode(), .master_select(ms),
        .transmit_select(ts), .iface_mode(md), .start_req(sr), .stop_req(sp), .soft_reset_busy(),
        .tx_data(), .tx_load(), .own_addr(), .idle_run(), .serial_bus_irq(irq));
    engine_model i_eng (.pclk(pclk), .presetn(presetn), .ev(ev), .start_req(sr),
        .xfer_done(xd), .stop_det(sd), .start_det(st), .arb_lost(al), .busy(bz));
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic summarize();
        if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 0; penable <= 0;
        // Checks after the call see the completing edge settled
        @(negedge pclk);
    endtask
    task automatic pulse(input logic [2:0] e);
        @(posedge pclk);
        ev <= e;
        @(posedge pclk);
        ev <= 3'h0;
        repeat (2) @(posedge pclk);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, OFS_TRANSFER_FORMAT_CTRL, 0); chk(rd, 32'h0);
        apb(1, OFS_IFACE_ENABLE_CTRL, 32'h80);
        apb(0, OFS_TRANSFER_FORMAT_CTRL, 0); chk(rd, 32'h09);
        apb(0, OFS_BUS_COMMAND_CTRL, 0); chk(rd, 32'h10);
        apb(1, OFS_TRANSFER_FORMAT_CTRL, 32'h70); chk({xc, db}, 8'h43);
        apb(1, OFS_TRANSFER_FORMAT_CTRL, 32'h10); chk({xc, db}, 8'h98);
        apb(1, OFS_TRANSFER_FORMAT_CTRL, 32'h40); chk({xc, db}, 8'h22);
        apb(1, OFS_TRANSFER_FORMAT_CTRL, 32'h00); chk({xc, db}, 8'h88);
        apb(1, OFS_TRANSFER_FORMAT_CTRL, 32'h40);
        apb(1, OFS_BUS_COMMAND_CTRL, 32'he8); chk({ms, ts, md, sr}, 5'h1d);
        // Two SCL ticks on code 000, one period apart
        do @(posedge pclk); while (tk !== 1'b1);
        t0 = cyc;
        do @(posedge pclk); while (tk !== 1'b1);
        chk(cyc - t0, (1 << SCL_EXP_BASE) + SCL_OFFSET);
        pulse(3'h3); chk(db, 4'h8);
        pulse(3'h1); chk(irq, 1'b1);
        apb(0, OFS_BUS_COMMAND_CTRL, 0); chk(rd, 32'he0);
        pulse(3'h2); chk({ms, ts}, 2'h0);
        apb(0, OFS_BUS_COMMAND_CTRL, 0); chk(rd, 32'h00);
        apb(1, OFS_BUS_COMMAND_CTRL, 32'h08); chk({irq, sp}, 2'h3);
        apb(1, OFS_BUS_COMMAND_CTRL, 32'h18); chk(irq, 1'b0);
        apb(1, OFS_BUS_COMMAND_CTRL, 32'hc8); pulse(3'h4); chk({ms, ts, irq}, 3'h1);
        apb(0, OFS_BUS_COMMAND_CTRL, 0); chk(rd, 32'h08);
        apb(1, OFS_IFACE_ENABLE_CTRL, 32'h00); chk(ge, 1'b0);
        apb(1, OFS_TRANSFER_FORMAT_CTRL, 32'hf0); apb(1, OFS_IFACE_ENABLE_CTRL, 32'h80);
        apb(0, OFS_TRANSFER_FORMAT_CTRL, 0); chk(rd, 32'h09);
        apb(1, OFS_BUS_COMMAND_CTRL, 32'h14); chk(md, MODE_SIO);
        apb(1, OFS_BUS_COMMAND_CTRL, 32'h02); apb(1, OFS_BUS_COMMAND_CTRL, 32'h01);
        chk(md, MODE_I2C);
        apb(0, OFS_TRANSFER_FORMAT_CTRL, 0); chk(rd, 32'h08);
        repeat (8) @(posedge pclk);
        apb(0, OFS_TRANSFER_FORMAT_CTRL, 0); chk(rd[0], 1'b1);
        apb(0, 8'h20, 0); chk(se, 1'b1);
        chk(rd, 32'h0);
        summarize();
    end
endmodule
`default_nettype wire
